// File: hw/dtec_consts.vh
// Purpose: Constants for the dual 8-bit timer/event counter block
// Assumes: Avalon-MM word addressing by byte address, 32-bit data
// Notes: Register byte addresses are four times the register index
`ifndef DTEC_CONSTS_VH
`define DTEC_CONSTS_VH

// ****************************************
// Register indices
// ****************************************
`define DTEC_IDX_CLK_SEL 16'hFF41
`define DTEC_IDX_MODE 16'hFF49
`define DTEC_IDX_OUT_CTL 16'hFF4A
`define DTEC_IDX_CMP_ONE 16'hFF4B
`define DTEC_IDX_CMP_TWO 16'hFF4C
`define DTEC_IDX_CNT 16'hFF4D
`define DTEC_IDX_OSC 16'hFF4E
`define DTEC_IDX_IRQ_STAT 16'hFF4F
`define DTEC_IDX_IRQ_MASK 16'hFF50

// ****************************************
// Field positions
// ****************************************
`define DTEC_MODE_RUN_ONE 0
`define DTEC_MODE_RUN_TWO 1
`define DTEC_MODE_CASCADE 2
`define DTEC_OUT_EN_ONE 0
`define DTEC_OUT_SET_ONE 1
`define DTEC_OUT_RST_ONE 2
`define DTEC_OUT_EN_TWO 4
`define DTEC_OUT_SET_TWO 5
`define DTEC_OUT_RST_TWO 6
`define DTEC_OUT_RD_MASK 8'h11

// ****************************************
// Clock select codes and reset values
// ****************************************
`define DTEC_SEL_FALL 4'h0
`define DTEC_SEL_RISE 4'h1
`define DTEC_SEL_DIV_LO 4'h6
`define DTEC_SEL_DIV_TOP 4'hF
`define DTEC_DIV_TOP_EXP 4'hB
`define DTEC_DIV_BASE_EXP 4'h5
`define DTEC_RST_BYTE 8'h00
`define DTEC_RST_OSC 1'h0

`endif

// File: hw/dtec_timer.v
// Purpose: Two 8-bit timer/event counters, cascadable to 16 bits, Avalon-MM slave
// Assumes: Event inputs asynchronous in timing to sys_clk_i; one clock domain
// Notes: Prohibited clock select codes leave the channel without a count clock
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.vh"

module dtec_timer #(
  parameter PRE_W = 13
)
(
  input wire sys_clk_i,
  input wire rst_i,
  input wire [15:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output wire [1:0] avs_response_o,
  input wire chan_one_event_input_i,
  input wire chan_two_event_input_i,
  output wire chan_one_wave_output_o,
  output wire chan_two_wave_output_o,
  output wire irq_o
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Is a clock select code one of the divided clock choices
  function sel_is_div;
    input [3:0] code;
    begin
      sel_is_div = (code >= `DTEC_SEL_DIV_LO);
    end
  endfunction

  // Prescaler bit index whose rising toggle gives the selected division
  function [3:0] sel_exp;
    input [3:0] code;
    begin
      if (code == `DTEC_SEL_DIV_TOP)
        sel_exp = `DTEC_DIV_TOP_EXP - 4'h1;
      else
        sel_exp = code - `DTEC_DIV_BASE_EXP - 4'h1;
    end
  endfunction

  // One count tick for a code, from event edges and prescaler ticks
  function sel_tick;
    input [3:0] code;
    input rise;
    input fall;
    input [PRE_W-1:0] ticks;
    begin
      if (code == `DTEC_SEL_FALL)
        sel_tick = fall;
      else if (code == `DTEC_SEL_RISE)
        sel_tick = rise;
      else if (sel_is_div(code))
        sel_tick = ticks[sel_exp(code)];
      else
        sel_tick = 1'b0;
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] clk_sel_ff;
  reg [7:0] mode_ff;
  reg [7:0] out_ctl_ff;
  reg [7:0] cmp_one_ff;
  reg [7:0] cmp_two_ff;
  reg osc_mode_bit_ff;
  reg [1:0] irq_stat_ff;
  reg [1:0] irq_mask_ff;
  reg [7:0] cnt_one_ff;
  reg [7:0] cnt_two_ff;
  reg [1:0] wave_ff;
  reg [1:0] ev_s1_ff;
  reg [1:0] ev_s2_ff;
  reg [1:0] ev_s3_ff;
  reg half_ff;
  reg [PRE_W-1:0] pre_ff;
  reg [PRE_W-1:0] pre_prev_ff;
  reg [31:0] rdata_ff;
  reg rvalid_ff;
  reg err_ff;

  wire run_one = mode_ff[`DTEC_MODE_RUN_ONE];
  wire run_two = mode_ff[`DTEC_MODE_RUN_TWO];
  wire cascade = mode_ff[`DTEC_MODE_CASCADE];
  wire req = avs_read_i | avs_write_i;
  // Registers sit at the top of the index space; the two index bits above the bus are implied set
  wire [15:0] idx = {2'h3, avs_address_i[15:2]};
  // A write lands only on the edge where waitrequest is low
  wire wr_lo = avs_write_i & avs_byteenable_i[0] & rvalid_ff;
  wire hit = (idx == `DTEC_IDX_CLK_SEL) | (idx == `DTEC_IDX_MODE) |
    (idx == `DTEC_IDX_OUT_CTL) | (idx == `DTEC_IDX_CMP_ONE) |
    (idx == `DTEC_IDX_CMP_TWO) | (idx == `DTEC_IDX_CNT) |
    (idx == `DTEC_IDX_OSC) | (idx == `DTEC_IDX_IRQ_STAT) |
    (idx == `DTEC_IDX_IRQ_MASK);

  // ****************************************
  // Event input synchronisers and prescaler
  // ****************************************

  // Two flops for metastability, third for edge detection
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ev_s1_ff <= 2'h0;
      ev_s2_ff <= 2'h0;
      ev_s3_ff <= 2'h0;
    end
    else
    begin
      ev_s1_ff <= {chan_two_event_input_i, chan_one_event_input_i};
      ev_s2_ff <= ev_s1_ff;
      ev_s3_ff <= ev_s2_ff;
    end
  end

  wire [1:0] ev_rise = ev_s2_ff & ~ev_s3_ff;
  wire [1:0] ev_fall = ~ev_s2_ff & ev_s3_ff;

  // Source enable: every cycle or every second cycle
  wire src_en = osc_mode_bit_ff | half_ff;
  wire [PRE_W-1:0] nxt_pre = pre_ff + {{(PRE_W-1){1'b0}}, 1'b1};
  wire [PRE_W-1:0] pre_tick = pre_ff & ~pre_prev_ff;

  // Free running prescaler; a bit rising marks one divided period
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      half_ff <= 1'b0;
      pre_ff <= {PRE_W{1'b0}};
      pre_prev_ff <= {PRE_W{1'b0}};
    end
    else
    begin
      half_ff <= ~half_ff;
      pre_prev_ff <= pre_ff;
      if (src_en)
        pre_ff <= nxt_pre;
    end
  end

  // ****************************************
  // Count clocks and counters
  // ****************************************
  wire tick_one = sel_tick(clk_sel_ff[3:0], ev_rise[0], ev_fall[0], pre_tick);
  wire tick_two_own = sel_tick(clk_sel_ff[7:4], ev_rise[1], ev_fall[1], pre_tick);
  // Cascade ignores the high nibble and channel two run bit
  wire tick_two = cascade ? tick_one : tick_two_own;
  wire en_one = run_one;
  wire en_two = cascade ? run_one : run_two;
  wire match_one = (cnt_one_ff == cmp_one_ff);
  wire match_two = (cnt_two_ff == cmp_two_ff);
  wire match16 = match_one & match_two;
  // Per-channel match events, pulsed on the tick that completes the count
  wire [1:0] hit_now;
  assign hit_now[0] = cascade ? (en_one & tick_one & match16) : (en_one & tick_one & match_one);
  assign hit_now[1] = cascade ? 1'b0 : (en_two & tick_two & match_two);

  // Counters: match clears on the next tick, so interval is compare+1
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_one_ff <= `DTEC_RST_BYTE;
      cnt_two_ff <= `DTEC_RST_BYTE;
    end
    else
    begin
      if (!en_one)
        cnt_one_ff <= `DTEC_RST_BYTE;
      else if (tick_one)
      begin
        if (cascade ? match16 : match_one)
          cnt_one_ff <= `DTEC_RST_BYTE;
        else
          cnt_one_ff <= cnt_one_ff + 8'h01;
      end
      if (!en_two)
        cnt_two_ff <= `DTEC_RST_BYTE;
      else if (cascade)
      begin
        // High byte advances when low byte wraps
        if (tick_one && match16)
          cnt_two_ff <= `DTEC_RST_BYTE;
        else if (tick_one && cnt_one_ff == 8'hFF)
          cnt_two_ff <= cnt_two_ff + 8'h01;
      end
      else if (tick_two)
      begin
        if (match_two)
          cnt_two_ff <= `DTEC_RST_BYTE;
        else
          cnt_two_ff <= cnt_two_ff + 8'h01;
      end
    end
  end

  // Square wave outputs toggle per match, software may force a level
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      wave_ff <= 2'h0;
    else
    begin
      if (wr_lo && idx == `DTEC_IDX_OUT_CTL && avs_writedata_i[`DTEC_OUT_SET_ONE])
        wave_ff[0] <= 1'b1;
      else if (wr_lo && idx == `DTEC_IDX_OUT_CTL && avs_writedata_i[`DTEC_OUT_RST_ONE])
        wave_ff[0] <= 1'b0;
      else if (hit_now[0])
        wave_ff[0] <= ~wave_ff[0];
      if (wr_lo && idx == `DTEC_IDX_OUT_CTL && avs_writedata_i[`DTEC_OUT_SET_TWO])
        wave_ff[1] <= 1'b1;
      else if (wr_lo && idx == `DTEC_IDX_OUT_CTL && avs_writedata_i[`DTEC_OUT_RST_TWO])
        wave_ff[1] <= 1'b0;
      else if (hit_now[1])
        wave_ff[1] <= ~wave_ff[1];
    end
  end

  assign chan_one_wave_output_o = wave_ff[0] & out_ctl_ff[`DTEC_OUT_EN_ONE];
  assign chan_two_wave_output_o = wave_ff[1] & out_ctl_ff[`DTEC_OUT_EN_TWO];

  // ****************************************
  // Register file and Avalon-MM slave
  // ****************************************

  // Write one clears a status bit; a match in the same cycle wins
  wire [1:0] stat_clr = (wr_lo && idx == `DTEC_IDX_IRQ_STAT) ? avs_writedata_i[1:0] : 2'h0;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      clk_sel_ff <= `DTEC_RST_BYTE;
      mode_ff <= `DTEC_RST_BYTE;
      out_ctl_ff <= `DTEC_RST_BYTE;
      cmp_one_ff <= `DTEC_RST_BYTE;
      cmp_two_ff <= `DTEC_RST_BYTE;
      osc_mode_bit_ff <= `DTEC_RST_OSC;
      irq_stat_ff <= 2'h0;
      irq_mask_ff <= 2'h0;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~stat_clr) | hit_now;
      if (wr_lo)
      begin
        case (idx)
          `DTEC_IDX_CLK_SEL: clk_sel_ff <= avs_writedata_i[7:0];
          `DTEC_IDX_MODE: mode_ff <= avs_writedata_i[7:0] & 8'h07;
          `DTEC_IDX_OUT_CTL: out_ctl_ff <= avs_writedata_i[7:0] & `DTEC_OUT_RD_MASK;
          `DTEC_IDX_CMP_ONE: cmp_one_ff <= avs_writedata_i[7:0];
          `DTEC_IDX_CMP_TWO: cmp_two_ff <= avs_writedata_i[7:0];
          `DTEC_IDX_OSC: osc_mode_bit_ff <= avs_writedata_i[0];
          `DTEC_IDX_IRQ_MASK: irq_mask_ff <= avs_writedata_i[1:0];
          default: ;
        endcase
      end
    end
  end

  // Read mux; level set/reset bits are never stored so read zero
  reg [31:0] nxt_rdata;
  always @*
  begin
    nxt_rdata = 32'h0;
    case (idx)
      `DTEC_IDX_CLK_SEL: nxt_rdata[7:0] = clk_sel_ff;
      `DTEC_IDX_MODE: nxt_rdata[7:0] = mode_ff;
      `DTEC_IDX_OUT_CTL: nxt_rdata[7:0] = out_ctl_ff & `DTEC_OUT_RD_MASK;
      `DTEC_IDX_CMP_ONE: nxt_rdata[7:0] = cmp_one_ff;
      `DTEC_IDX_CMP_TWO: nxt_rdata[7:0] = cmp_two_ff;
      `DTEC_IDX_CNT: nxt_rdata[15:0] = {cnt_two_ff, cnt_one_ff};
      `DTEC_IDX_OSC: nxt_rdata[0] = osc_mode_bit_ff;
      `DTEC_IDX_IRQ_STAT: nxt_rdata[1:0] = irq_stat_ff;
      `DTEC_IDX_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
      default: nxt_rdata = 32'h0;
    endcase
  end

  // One wait cycle per access: request seen, answer next cycle
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      err_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= req & ~rvalid_ff;
      if (req && !rvalid_ff)
      begin
        rdata_ff <= avs_read_i ? nxt_rdata : 32'h0;
        err_ff <= ~hit;
      end
    end
  end

  assign avs_waitrequest_o = req & ~rvalid_ff;
  assign avs_readdata_o = rdata_ff;
  assign avs_response_o = (rvalid_ff & err_ff) ? 2'h2 : 2'h0;
  assign irq_o = |(irq_stat_ff & irq_mask_ff);

endmodule
`default_nettype wire

// File: tb/dtec_event_src.sv
// Purpose: Far-side model driving one event input pin
// Assumes: Pin changes just after a rising clock edge
// Notes: Idle level is low; each level stands hold_i+1 cycles
`timescale 1ns/1ps
`default_nettype none
module dtec_event_src (
  input wire logic sys_clk_i,
  input wire logic start_i,
  input wire logic [7:0] count_i,
  input wire logic [3:0] hold_i,
  output logic event_o,
  output logic busy_o
);
  logic [8:0] steps_ff = 9'h000;
  logic [3:0] dwell_ff = 4'h0;
  logic level_ff = 1'b0;
  // One pulse is two level changes, each held hold_i+1 cycles
  always @(posedge sys_clk_i)
  begin
    if (start_i)
    begin
      steps_ff <= {count_i, 1'b0};
      dwell_ff <= hold_i;
    end
    else if (dwell_ff != 4'h0)
      dwell_ff <= dwell_ff - 4'h1;
    else if (steps_ff != 9'h000)
    begin
      level_ff <= ~level_ff;
      steps_ff <= steps_ff - 9'h001;
      dwell_ff <= hold_i;
    end
  end
  // Pin level and activity flag
  assign event_o = level_ff;
  assign busy_o = (steps_ff != 9'h000) || (dwell_ff != 4'h0);
endmodule
`default_nettype wire

// File: tb/dtec_timer_properties.sv
// Purpose: Port checks for the timer block
// Assumes: One clock, rst_i async active high
// Notes: Bound to every timer instance
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.vh"
module dtec_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic chan_one_wave_output_o,
  input wire logic chan_two_wave_output_o,
  input wire logic irq_o
);
  // Request decode
  wire logic [13:0] ix = avs_address_i[15:2];
  wire logic req = avs_read_i | avs_write_i;
  wire logic done = req & ~avs_waitrequest_o;
  wire logic wr0 = done & avs_write_i & avs_byteenable_i[0];
  wire logic hit = (ix == 14'(`DTEC_IDX_CLK_SEL)) ||
    (ix >= 14'(`DTEC_IDX_MODE) && ix <= 14'(`DTEC_IDX_IRQ_MASK));
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_o)
    else $error("no wait state");
  a_wait_one: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("extra wait state");
  a_resp_ok: assert property (done && hit |-> avs_response_o == 2'h0)
    else $error("bad response");
  a_resp_err: assert property (done && !hit |-> avs_response_o == 2'h2)
    else $error("missing error response");
  a_unmap_zero: assert property (done && avs_read_i && !hit |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_lvl_zero: assert property (done && avs_read_i && ix == 14'(`DTEC_IDX_OUT_CTL) |->
    (avs_readdata_o & 32'hFFFFFFEE) == 32'h0) else $error("level bits read back");
  a_irq_masked: assert property (wr0 && ix == 14'(`DTEC_IDX_IRQ_MASK) &&
    avs_writedata_i[1:0] == 2'h0 |-> ##2 !irq_o) else $error("irq while masked");
  a_wave_one_off: assert property (wr0 && ix == 14'(`DTEC_IDX_OUT_CTL) &&
    !avs_writedata_i[0] |-> ##2 !chan_one_wave_output_o) else $error("wave one not gated");
  a_wave_two_off: assert property (wr0 && ix == 14'(`DTEC_IDX_OUT_CTL) &&
    !avs_writedata_i[4] |-> ##2 !chan_two_wave_output_o) else $error("wave two not gated");
endmodule
bind dtec_timer dtec_chk chk_u (.*);
`default_nettype wire

// File: tb/dtec_timer_tb.sv
// Purpose: Self-checking bench for the timer block
// Assumes: One Avalon-MM request at a time
// Notes: Event pins come from two far-side models
`timescale 1ns/1ps
`default_nettype none
`include "dtec_consts.vh"
module dtec_timer_tb;
  localparam logic [15:0] CS = `DTEC_IDX_CLK_SEL, MD = `DTEC_IDX_MODE, OC = `DTEC_IDX_OUT_CTL;
  localparam logic [15:0] C1 = `DTEC_IDX_CMP_ONE, C2 = `DTEC_IDX_CMP_TWO, CN = `DTEC_IDX_CNT;
  localparam logic [15:0] OS = `DTEC_IDX_OSC, ST = `DTEC_IDX_IRQ_STAT, MK = `DTEC_IDX_IRQ_MASK;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic rd_q = 1'b0;
  logic wr_q = 1'b0;
  logic [3:0] be = 4'h1;
  logic [3:0] be_q = 4'h0;
  logic [15:0] adr_q = 16'h0;
  logic [31:0] wd_q = 32'h0;
  logic [1:0] go = 2'h0;
  logic [7:0] n1 = 8'h0;
  logic [7:0] n2 = 8'h0;
  wire logic [31:0] rdat;
  wire logic [1:0] rsp, wv, ev, busy;
  wire logic wait_o, irq;
  int num_errors = 0;
  int checks = 0;
  // Design and the two event sources, channel two slow
  dtec_timer dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(adr_q),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_byteenable_i(be_q), .avs_writedata_i(wd_q),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .avs_response_o(rsp),
    .chan_one_event_input_i(ev[0]), .chan_two_event_input_i(ev[1]),
    .chan_one_wave_output_o(wv[0]), .chan_two_wave_output_o(wv[1]), .irq_o(irq));
  dtec_event_src src1_u (.sys_clk_i(sys_clk), .start_i(go[0]), .count_i(n1), .hold_i(4'h1),
    .event_o(ev[0]), .busy_o(busy[0]));
  dtec_event_src src2_u (.sys_clk_i(sys_clk), .start_i(go[1]), .count_i(n2), .hold_i(4'h6),
    .event_o(ev[1]), .busy_o(busy[1]));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wr_q <= w;
    rd_q <= ~w;
    be_q <= be;
    adr_q <= {ix[13:0], 2'h0};
    wd_q <= {24'h0, d};
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    if (n == 20)
    begin
      num_errors++;
      end_sim;
    end
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
  endtask
  task automatic rd(input string nm, input logic [15:0] ix, input logic [31:0] e);
    bus(1'b0, ix, 8'h0);
    cmp(nm, e, rdat);
  endtask
  // Send pulses on both pins, then allow for the input synchroniser
  task automatic pulse(input logic [7:0] a, input logic [7:0] b);
    int n;
    n = 0;
    n1 <= a;
    n2 <= b;
    go <= 2'h3;
    @(posedge sys_clk);
    go <= 2'h0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (busy !== 2'h0 && n < 500);
    if (n == 500)
    begin
      num_errors++;
      end_sim;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  // Cycles between two successive toggles of one wave output
  task automatic meas(input int s, input int e);
    int n;
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      p = wv[s];
      do
      begin
        @(posedge sys_clk);
        n++;
      end while (wv[s] === p && n < 9000);
    end
    cmp("interval", e, n);
  endtask
  // Clock
  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  // Watchdog
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    num_errors++;
    end_sim;
  end
  // Test sequence
  initial
  begin
    int e;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rd("clock select", CS, 32'h0);
    rd("mode", MD, 32'h0);
    rd("unmapped", 16'h0100, 32'h0);
    cmp("response", 32'h2, {30'h0, rsp});
    wr(OC, 8'h33);
    rd("output control", OC, 32'h11);
    be = 4'h0;
    wr(C1, 8'h5A);
    be = 4'h1;
    rd("lane off", C1, 32'h0);
    $display("test registers done");
    wr(CS, 8'h01);
    wr(C1, 8'h02);
    wr(C2, 8'h01);
    wr(MK, 8'h03);
    wr(MD, 8'h03);
    pulse(8'h02, 8'h01);
    rd("count", CN, 32'h0102);
    wr(MD, 8'h00);
    rd("stopped count", CN, 32'h0);
    wr(MD, 8'h03);
    pulse(8'h02, 8'h01);
    rd("no match", ST, 32'h0);
    pulse(8'h01, 8'h01);
    rd("match count", CN, 32'h0);
    rd("status", ST, 32'h3);
    cmp("waves", 32'h0, {30'h0, wv});
    cmp("irq", 32'h1, {31'h0, irq});
    $display("test events done");
    wr(MK, 8'h00);
    rd("mask", MK, 32'h0);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(ST, 8'h02);
    rd("status clear", ST, 32'h1);
    wr(MK, 8'h03);
    rd("mask", MK, 32'h3);
    cmp("irq on", 32'h1, {31'h0, irq});
    wr(ST, 8'h01);
    rd("status", ST, 32'h0);
    cmp("irq off", 32'h0, {31'h0, irq});
    $display("test irq done");
    wr(MD, 8'h00);
    wr(OS, 8'h01);
    wr(C1, 8'h00);
    wr(C2, 8'h00);
    for (int c = 6; c < 16; c++)
    begin
      wr(MD, 8'h00);
      wr(CS, {c[3:0], c[3:0]});
      wr(MD, 8'h03);
      e = (c == 15) ? 2048 : (1 << (c - 5));
      meas(0, e);
      meas(1, e);
    end
    wr(MD, 8'h00);
    wr(OS, 8'h00);
    wr(CS, 8'h66);
    wr(MD, 8'h03);
    meas(0, 4);
    $display("test dividers done");
    wr(MD, 8'h00);
    wr(OS, 8'h01);
    wr(CS, 8'h26);
    wr(C1, 8'h01);
    wr(C2, 8'h01);
    wr(MD, 8'h05);
    meas(0, 516);
    $display("test cascade done");
    wr(MD, 8'h00);
    wr(OC, 8'h22);
    @(posedge sys_clk);
    cmp("waves gated", 32'h0, {30'h0, wv});
    wr(OC, 8'h11);
    @(posedge sys_clk);
    cmp("waves set", 32'h3, {30'h0, wv});
    $display("test wave gating done");
    end_sim;
  end
endmodule
`default_nettype wire
